// *** gsb_status_byte.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gsb_defines.svh"

module gsb_status_byte (
  input  wire logic             CLOCK_I,
  input  wire logic             RSTN_I,
  input  wire gsb_pkg::gsb_event_t EVENT_I,
  input  wire gsb_pkg::gsb_bus_t   BUS_I,
  input  wire logic             SPE_I,
  input  wire logic             SPD_I,
  output logic      [7:0]       POLL_BYTE_O,
  output logic                  POLL_DONE_O,
  output logic                  POLL_MODE_O,
  output logic                  SRQ_O,
  output logic                  SRQ_OE_O,
  output logic                  SRQ_LAMP_O,
  output logic                  BUS_ERROR_O,
  output logic      [7:0]       STATUS_O
);
  import gsb_pkg::*;

  logic       data_ready;
  logic       syntax_err;
  logic       busy;
  logic       service_request_flag;
  logic       data_ready_request_on;
  logic       poll_done;
  logic       dr_set;
  logic       dev_clear;
  logic [7:0] poll_status_byte;

  // Event strobes
  assign dr_set    = EVENT_I.meas_done && busy;
  assign dev_clear = BUS_I.device_clear;

  // Data ready flag; a new completion wins over a clear
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      data_ready <= 1'b0;
    end else if (dr_set) begin
      data_ready <= 1'b1;
    end else if (EVENT_I.output_start || EVENT_I.buffer_clear || poll_done) begin
      data_ready <= 1'b0;
    end
  end

  // Syntax error flag; set wins over poll or device clear
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      syntax_err <= 1'b0;
    end else if (EVENT_I.syntax_error) begin
      syntax_err <= 1'b1;
    end else if (poll_done || dev_clear) begin
      syntax_err <= 1'b0;
    end
  end

  // Busy while a measurement runs
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      busy <= 1'b0;
    end else if (EVENT_I.meas_done) begin
      busy <= 1'b0;
    end else if (EVENT_I.meas_start) begin
      busy <= 1'b1;
    end
  end

  // Data-ready request enable, set and cleared by commands
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      data_ready_request_on <= `GSB_DR_ENABLE_RESET;
    end else if (EVENT_I.dr_request_on) begin
      data_ready_request_on <= 1'b1;
    end else if (EVENT_I.dr_request_off) begin
      data_ready_request_on <= 1'b0;
    end
  end

  // Request-for-service flag
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      service_request_flag <= 1'b0;
    end else if (EVENT_I.syntax_error || (dr_set && data_ready_request_on)) begin
      service_request_flag <= 1'b1;
    end else if (poll_done || dev_clear) begin
      service_request_flag <= 1'b0;
    end
  end

  // Bus error on data request before results exist
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      BUS_ERROR_O <= 1'b0;
    end else begin
      BUS_ERROR_O <= BUS_I.data_request && !data_ready;
    end
  end

  // Assemble the byte from the four flags
  always_comb begin
    poll_status_byte = `GSB_RESET_VALUE;
    poll_status_byte[`GSB_BIT_DATA_READY]  = data_ready;
    poll_status_byte[`GSB_BIT_SYNTAX_ERR]  = syntax_err;
    poll_status_byte[`GSB_BIT_BUSY]        = busy;
    poll_status_byte[`GSB_BIT_SERVICE_REQ] = service_request_flag;
  end

  // Serial poll responder
  gsb_poll u_poll (
    .clock_i     (CLOCK_I),
    .rstn_i      (RSTN_I),
    .spe_i       (SPE_I),
    .spd_i       (SPD_I),
    .read_i      (BUS_I.poll_read),
    .status_i    (poll_status_byte),
    .poll_byte_o (POLL_BYTE_O),
    .poll_done_o (poll_done),
    .poll_mode_o (POLL_MODE_O)
  );

  // Outputs follow the flags
  assign POLL_DONE_O = poll_done;
  assign STATUS_O    = poll_status_byte;
  assign SRQ_O       = service_request_flag;
  assign SRQ_OE_O    = service_request_flag;
  assign SRQ_LAMP_O  = service_request_flag;

  // Named sequences for the poll handshake
  sequence poll_enter_s;
    SPE_I && !POLL_MODE_O;
  endsequence
  sequence poll_read_s;
    POLL_MODE_O && BUS_I.poll_read && !SPD_I;
  endsequence

  dr_sets_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    dr_set |=> data_ready) else $error("data ready not set");
  dr_clears_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    (EVENT_I.buffer_clear && !dr_set) |=> !data_ready) else $error("data ready kept");
  syn_sets_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    EVENT_I.syntax_error |=> syntax_err && service_request_flag) else $error("syntax lost");
  syn_holds_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    (syntax_err && !poll_done && !dev_clear) |=> syntax_err) else $error("syntax dropped");
  busy_tracks_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    EVENT_I.meas_done |=> !busy) else $error("busy stuck");
  dr_request_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    (dr_set && data_ready_request_on) |=> SRQ_O) else $error("no request on data");
  rqs_clears_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    ((dev_clear || poll_done) && !EVENT_I.syntax_error && !dr_set) |=> !service_request_flag)
    else $error("request not cleared");
  lamp_follow_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    SRQ_LAMP_O == STATUS_O[`GSB_BIT_SERVICE_REQ] && SRQ_O == SRQ_LAMP_O)
    else $error("lamp mismatch");
  poll_return_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    poll_enter_s ##1 poll_read_s |=> POLL_DONE_O && POLL_BYTE_O == $past(STATUS_O))
    else $error("poll byte wrong");
  unused_zero_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    (POLL_BYTE_O & ~`GSB_USED_MASK) == 8'h00) else $error("unused bits set");
  bus_err_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    (BUS_I.data_request && !data_ready) |=> BUS_ERROR_O) else $error("no bus error");

endmodule
`default_nettype wire

// *** gsb_defines.svh ***
`ifndef GSB_DEFINES_SVH
`define GSB_DEFINES_SVH

// Status byte field positions
`define GSB_BIT_DATA_READY   3'd0
`define GSB_BIT_SYNTAX_ERR   3'd1
`define GSB_BIT_BUSY         3'd4
`define GSB_BIT_SERVICE_REQ  3'd6
// Mask of the used status byte positions
`define GSB_USED_MASK        8'h53
// Reset value of the status byte
`define GSB_RESET_VALUE      8'h00
// Reset value of the data-ready request enable
`define GSB_DR_ENABLE_RESET  1'b0

`endif

// *** gsb_pkg.sv ***
package gsb_pkg;

  // Events reported to the status byte by the instrument core
  typedef struct packed {
    logic meas_start;
    logic meas_done;
    logic syntax_error;
    logic output_start;
    logic buffer_clear;
    logic dr_request_on;
    logic dr_request_off;
  } gsb_event_t;

  // Bus-side commands seen by the interface function
  typedef struct packed {
    logic device_clear;
    logic poll_read;
    logic data_request;
  } gsb_bus_t;

  // Serial poll tracking states
  typedef enum logic [1:0] {
    GSB_IDLE,
    GSB_ENABLED,
    GSB_SENT
  } gsb_poll_state_t;

endpackage

// *** gsb_poll.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gsb_defines.svh"

module gsb_poll (
  input  wire logic         clock_i,
  input  wire logic         rstn_i,
  input  wire logic         spe_i,
  input  wire logic         spd_i,
  input  wire logic         read_i,
  input  wire logic [7:0]   status_i,
  output logic      [7:0]   poll_byte_o,
  output logic              poll_done_o,
  output logic              poll_mode_o
);
  import gsb_pkg::*;

  gsb_poll_state_t state;

  // Poll mode sequencer, enabled by SPE and left by SPD
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      state <= GSB_IDLE;
    end else begin
      case (state)
        GSB_IDLE: begin
          if (spe_i) begin
            state <= GSB_ENABLED;
          end
        end
        GSB_ENABLED: begin
          if (spd_i) begin
            state <= GSB_IDLE;
          end else if (read_i) begin
            state <= GSB_SENT;
          end
        end
        GSB_SENT: begin
          if (spd_i) begin
            state <= GSB_IDLE;
          end
        end
        default: begin
          state <= GSB_IDLE;
        end
      endcase
    end
  end

  // Byte capture and one-cycle done pulse on the first read in poll mode
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      poll_byte_o <= 8'h00;
      poll_done_o <= 1'b0;
    end else begin
      poll_done_o <= 1'b0;
      if (state == GSB_ENABLED && read_i && !spd_i) begin
        poll_byte_o <= status_i & `GSB_USED_MASK;
        poll_done_o <= 1'b1;
      end
    end
  end

  assign poll_mode_o = (state != GSB_IDLE);

endmodule
`default_nettype wire

// *** gsb_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module gsb_host (
  input  wire logic              clock_i,
  input  wire logic              poll_done_i,
  input  wire logic [7:0]        poll_byte_i,
  output var  gsb_pkg::gsb_bus_t bus_o,
  output var  logic              spe_o,
  output var  logic              spd_o
);
  import gsb_pkg::*;
  // Controller idles with no bus command
  initial begin
    bus_o = '0;
    spe_o = 1'b0;
    spd_o = 1'b0;
  end
  // Serial poll: enable, one read, wait for the byte, disable
  task automatic poll(output logic [7:0] b);
    int i;
    @(posedge clock_i) spe_o <= 1'b1;
    @(posedge clock_i) begin
      spe_o <= 1'b0;
      bus_o <= gsb_bus_t'(3'h2);
    end
    @(posedge clock_i) bus_o <= '0;
    // Look at the done pulse once it has settled after the edge
    #1;
    for (i = 0; i < 4 && poll_done_i !== 1'b1; i++) begin
      @(posedge clock_i);
      #1;
    end
    b = poll_byte_i;
    @(posedge clock_i) spd_o <= 1'b1;
    @(posedge clock_i) spd_o <= 1'b0;
  endtask
  // One-cycle bus command: device clear, poll read or data request
  task automatic pulse(input logic [2:0] v);
    @(posedge clock_i) bus_o <= gsb_bus_t'(v);
    @(posedge clock_i) bus_o <= '0;
  endtask
endmodule
`default_nettype wire

// *** gsb_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import gsb_pkg::*;
  localparam int MS = 6, MD = 5, SE = 4, OS = 3, CLR = 2, ON = 1, OFF = 0;
  localparam int DQ = 8, PR = 9, DC = 11;
  logic       CLOCK_I, RSTN_I, spe, spd, done, mode, srq, srq_oe, lamp, berr;
  logic [7:0] pbyte, status, b;
  gsb_event_t ev;
  gsb_bus_t   bus;
  int         errors, n_tests;
  gsb_status_byte gsb_status_byte_inst (.CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I),
    .EVENT_I(ev), .BUS_I(bus), .SPE_I(spe), .SPD_I(spd), .POLL_BYTE_O(pbyte),
    .POLL_DONE_O(done), .POLL_MODE_O(mode), .SRQ_O(srq), .SRQ_OE_O(srq_oe),
    .SRQ_LAMP_O(lamp), .BUS_ERROR_O(berr), .STATUS_O(status));
  gsb_host gsb_host_inst (.clock_i(CLOCK_I), .poll_done_i(done),
    .poll_byte_i(pbyte), .bus_o(bus), .spe_o(spe), .spd_o(spd));
  // Clock generator
  initial begin
    CLOCK_I = 1'b0;
    forever #10 CLOCK_I = ~CLOCK_I;
  end
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict
  task automatic results;
    $display("errors %0d, checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Pulse an event or a bus command, then check byte and request outputs
  task automatic pe(input int k, input logic [7:0] exp);
    if (k < 7) begin
      @(posedge CLOCK_I) ev <= gsb_event_t'(7'h01 << k);
      @(posedge CLOCK_I) ev <= '0;
    end else gsb_host_inst.pulse(3'(k - 7));
    #1;
    chk(status, exp);
    chk({5'h00, srq, srq_oe, lamp}, {5'h00, {3{exp[6]}}});
  endtask
  // Busy and data ready with the request enable off
  task automatic t_meas;
    pe(MS, 8'h10);
    pe(MD, 8'h01);
    pe(CLR, 8'h00);
    pe(MS, 8'h10);
    pe(MD, 8'h01);
    pe(OS, 8'h00);
  endtask
  // Poll with every used bit set; busy survives the poll
  task automatic t_poll;
    pe(MS, 8'h10);
    pe(MD, 8'h01);
    pe(SE, 8'h43);
    pe(MS, 8'h53);
    // Poll mode must stand while the controller reads the byte
    fork
      gsb_host_inst.poll(b);
      begin
        repeat (2) @(posedge CLOCK_I);
        #1;
        chk({7'h00, mode}, 8'h01);
      end
    join
    #1;
    chk(b, 8'h53);
    chk(status, 8'h10);
    chk({7'h00, mode}, 8'h00);
    pe(MD, 8'h01);
    pe(CLR, 8'h00);
  endtask
  // Data ready raises a request only while enabled
  task automatic t_srq;
    pe(ON, 8'h00);
    pe(MS, 8'h10);
    pe(MD, 8'h41);
    pe(OS, 8'h40);
    pe(DC, 8'h00);
    pe(OFF, 8'h00);
    pe(MS, 8'h10);
    pe(MD, 8'h01);
    pe(CLR, 8'h00);
  endtask
  // Syntax error survives buffer clear, output and a read outside poll mode
  task automatic t_syn;
    pe(SE, 8'h42);
    pe(PR, 8'h42);
    pe(CLR, 8'h42);
    pe(OS, 8'h42);
    pe(DC, 8'h00);
  endtask
  // Early data request gives a bus error, a late one does not
  task automatic t_err;
    pe(DQ, 8'h00);
    chk({7'h00, berr}, 8'h01);
    pe(MS, 8'h10);
    pe(MD, 8'h01);
    pe(DQ, 8'h01);
    chk({7'h00, berr}, 8'h00);
  endtask
  // Reset, then the scenarios
  initial begin
    RSTN_I = 1'b0;
    ev = '0;
    errors = 0;
    n_tests = 0;
    repeat (2) @(posedge CLOCK_I);
    RSTN_I <= 1'b1;
    #1;
    chk(status, 8'h00);
    chk({5'h00, srq, srq_oe, berr}, 8'h00);
    t_meas;
    t_poll;
    t_srq;
    t_syn;
    t_err;
    results;
  end
  // Watchdog
  initial begin
    repeat (1000) @(posedge CLOCK_I);
    errors++;
    results;
  end
endmodule
`default_nettype wire
